/* hdl/rib_unit.sv */
// rib_unit.sv: relative and pointer branch decode/execute unit of the 8-bit core
// assumes opcode, displacement and register values are stable while start_i is high
// and that the fetch path delivers the displacement byte with the opcode
//
// Overview of operation
// - opcode 30 jumps relative when carry clear
// - opcode 28 jumps relative when zero set
// - opcode 20 jumps relative when zero clear
// - signed displacement, reach measured from opcode address plus two
// - untaken branch continues after two-byte instruction
// - taken conditional jump: 4,3,5 states
// - untaken conditional jump: 4,3 states
// - these instructions never change any flag
// - opcode E9 loads counter from pointer pair
// - DD E9 loads counter from first index
// - FD E9 loads counter from second index
// - opcode 10 decrements count, branches if nonzero
// - loop timing 5,3,5 taken; 5,3 fallthrough
// - opcode 18 always jumps, 4,3,5 states
`timescale 1ns/1ns
`include "rib_cfg.svh"

module rib_unit #(
  parameter int STATE_CLOCKS = `RIB_STATE_CLOCKS // core clocks per clock state
) (
  input  wire logic        clk_i,            // core clock, 250 MHz
  input  wire logic        reset_n_i,        // asynchronous reset, active low
  input  wire logic        start_i,          // opcode byte presented, one cycle
  input  wire logic [7:0]  opcode_i,         // first instruction byte
  input  wire logic [7:0]  second_i,         // byte after opcode (e9 or displacement)
  input  wire logic [15:0] opcode_addr_i,    // address of the opcode byte
  input  wire logic [7:0]  flags_i,          // flag register
  input  wire logic [7:0]  loop_count_i,     // loop count register
  input  wire logic [15:0] pointer_pair_i,   // primary pointer pair
  input  wire logic [15:0] first_index_i,    // first index pair
  input  wire logic [15:0] second_index_i,   // second index pair
  output logic             busy_o,           // sequence in progress
  output logic             done_o,           // retire pulse
  output logic             handled_o,        // last opcode was ours
  output logic             taken_o,          // last branch was taken
  output logic [15:0]      program_counter_o,// next fetch address
  output logic [7:0]       flags_o,          // flag register after the instruction
  output logic [7:0]       loop_count_o,     // loop count after the instruction
  output logic             loop_count_we_o,  // loop count write, with done
  output logic [3:0]       mcycles_o,        // machine cycles used
  output logic [4:0]       tstates_o         // clock states used
);

  // refuse a divider the counter cannot hold
  initial begin
    if (STATE_CLOCKS < 1 || STATE_CLOCKS > 255) begin
      $error("rib_unit: STATE_CLOCKS out of range");
    end
  end

  // ---- clock-state enable divider ----
  logic [7:0] div_r;          // clocks within one state
  logic [7:0] div_nxt;
  logic       tick;           // one-cycle pulse per clock state

  always_comb begin
    tick    = (div_r == 8'(STATE_CLOCKS - 1));
    div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ---- decode helpers ----
  // classify an opcode byte; used for the first byte only, the byte after a prefix is compared directly
  function automatic rib_pkg::rib_kind_t kind_of(input logic [7:0] op);
    if (op == `RIB_OP_JR_UNCOND || op == `RIB_OP_JR_CARRY_CLR ||
        op == `RIB_OP_JR_ZERO_SET || op == `RIB_OP_JR_ZERO_CLR) begin
      kind_of = rib_pkg::RIB_K_JR;
    end else if (op == `RIB_OP_JP_POINTER) begin
      kind_of = rib_pkg::RIB_K_JP;
    end else if (op == `RIB_OP_LOOP) begin
      kind_of = rib_pkg::RIB_K_LOOP;
    end else if (op == `RIB_OP_PFX_FIRST || op == `RIB_OP_PFX_SECOND) begin
      kind_of = rib_pkg::RIB_K_PFX;
    end else begin
      kind_of = rib_pkg::RIB_K_NONE;
    end
  endfunction : kind_of

  // condition of a relative jump against the flags
  function automatic logic cond_of(input logic [7:0] op, input logic [7:0] fl);
    if (op == `RIB_OP_JR_CARRY_CLR) begin
      cond_of = ~fl[`RIB_FLAG_CARRY_BIT];
    end else if (op == `RIB_OP_JR_ZERO_SET) begin
      cond_of = fl[`RIB_FLAG_ZERO_BIT];
    end else if (op == `RIB_OP_JR_ZERO_CLR) begin
      cond_of = ~fl[`RIB_FLAG_ZERO_BIT];
    end else begin
      cond_of = 1'b1;
    end
  endfunction : cond_of

  // ---- sequencer ----
  rib_pkg::rib_state_t state_r, state_nxt;
  logic [3:0]  left_r, left_nxt;        // states left in current machine cycle
  logic        go_r, go_nxt;            // branch will be taken
  logic [15:0] target_r, target_nxt;    // address loaded when taken
  logic [15:0] seq_r, seq_nxt;          // address after the two-byte form
  logic        loop_r, loop_nxt;        // instruction is the counted loop
  logic        two_r, two_nxt;          // instruction has displacement byte
  logic        pfx_r, pfx_nxt;          // instruction came through an index prefix
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  fl_r, fl_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        cnt_we_r, cnt_we_nxt;
  logic        done_r, done_nxt;
  logic        handled_r, handled_nxt;
  logic        taken_r, taken_nxt;
  logic [3:0]  mc_r, mc_nxt;
  logic [4:0]  ts_r, ts_nxt;
  logic        last_state;              // final state of a machine cycle
  logic [15:0] disp_ext;                // sign-extended displacement
  logic [7:0]  cnt_dec;                 // decremented loop count
  rib_pkg::rib_kind_t kind;

  always_comb begin
    kind       = kind_of(opcode_i);
    disp_ext   = {{8{second_i[7]}}, second_i};
    cnt_dec    = 8'(loop_count_i - 8'h01);
    last_state = tick && (left_r == 4'h1);
    state_nxt  = state_r;
    left_nxt   = left_r;
    go_nxt     = go_r;
    target_nxt = target_r;
    seq_nxt    = seq_r;
    loop_nxt   = loop_r;
    two_nxt    = two_r;
    pfx_nxt    = pfx_r;
    pc_nxt     = pc_r;
    fl_nxt     = fl_r;
    cnt_nxt    = cnt_r;
    cnt_we_nxt = 1'b0;
    done_nxt   = 1'b0;
    handled_nxt = handled_r;
    taken_nxt  = taken_r;
    mc_nxt     = mc_r;
    ts_nxt     = ts_r;
    // count clock states while busy
    if (tick && state_r != rib_pkg::RIB_IDLE && state_r != rib_pkg::RIB_DONE) begin
      ts_nxt   = 5'(ts_r + 5'h01);
      left_nxt = 4'(left_r - 4'h1);
    end
    case (state_r)
      rib_pkg::RIB_IDLE: begin
        if (start_i) begin
          // flags pass through untouched by every form here
          fl_nxt   = flags_i;
          seq_nxt  = 16'(opcode_addr_i + 16'h0002);
          target_nxt = 16'(seq_nxt + disp_ext);
          loop_nxt = (kind == rib_pkg::RIB_K_LOOP);
          two_nxt  = (kind == rib_pkg::RIB_K_JR) || (kind == rib_pkg::RIB_K_LOOP);
          pfx_nxt  = (kind == rib_pkg::RIB_K_PFX);
          mc_nxt   = 4'h1;
          ts_nxt   = 5'h00;
          handled_nxt = 1'b1;
          cnt_nxt  = loop_count_i;
          if (kind == rib_pkg::RIB_K_JR) begin
            go_nxt   = cond_of(opcode_i, flags_i);
            left_nxt = `RIB_T_FETCH;
            state_nxt = rib_pkg::RIB_FETCH;
          end else if (kind == rib_pkg::RIB_K_LOOP) begin
            cnt_nxt  = cnt_dec;
            go_nxt   = (cnt_dec != 8'h00);
            left_nxt = `RIB_T_FETCH_LOOP;
            state_nxt = rib_pkg::RIB_FETCH;
          end else if (kind == rib_pkg::RIB_K_JP) begin
            go_nxt   = 1'b1;
            target_nxt = pointer_pair_i;
            left_nxt = `RIB_T_FETCH;
            state_nxt = rib_pkg::RIB_FETCH;
          end else if (kind == rib_pkg::RIB_K_PFX &&
                       second_i == `RIB_OP_JP_POINTER) begin
            go_nxt   = 1'b1;
            target_nxt = (opcode_i == `RIB_OP_PFX_FIRST) ? first_index_i
                                                         : second_index_i;
            left_nxt = `RIB_T_FETCH;
            state_nxt = rib_pkg::RIB_FETCH;
          end else begin
            // not one of ours: report and stay idle
            handled_nxt = 1'b0;
            taken_nxt   = 1'b0;
            done_nxt    = 1'b1;
            mc_nxt      = 4'h0;
          end
        end
      end
      rib_pkg::RIB_FETCH: begin
        if (last_state) begin
          if (two_r) begin
            mc_nxt    = 4'(mc_r + 4'h1);
            left_nxt  = `RIB_T_DISP_READ;
            state_nxt = rib_pkg::RIB_DISP;
          end else if (pfx_r) begin
            // prefix fetched; the jump byte costs a second four-state cycle
            mc_nxt    = 4'(mc_r + 4'h1);
            left_nxt  = `RIB_T_PFX_FETCH;
            state_nxt = rib_pkg::RIB_PFX;
          end else begin
            state_nxt = rib_pkg::RIB_DONE;
          end
        end
      end
      rib_pkg::RIB_PFX: begin
        if (last_state) begin
          state_nxt = rib_pkg::RIB_DONE;
        end
      end
      rib_pkg::RIB_DISP: begin
        if (last_state) begin
          if (go_r) begin
            mc_nxt    = 4'(mc_r + 4'h1);
            left_nxt  = `RIB_T_ADD;
            state_nxt = rib_pkg::RIB_ADD;
          end else begin
            state_nxt = rib_pkg::RIB_DONE;
          end
        end
      end
      rib_pkg::RIB_ADD: begin
        if (last_state) begin
          state_nxt = rib_pkg::RIB_DONE;
        end
      end
      rib_pkg::RIB_DONE: begin
        pc_nxt     = go_r ? target_r : seq_r;
        taken_nxt  = go_r;
        cnt_we_nxt = loop_r;
        done_nxt   = 1'b1;
        state_nxt  = rib_pkg::RIB_IDLE;
      end
      default: begin
        state_nxt = rib_pkg::RIB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r   <= rib_pkg::RIB_IDLE;
      left_r    <= 4'h0;
      go_r      <= 1'b0;
      target_r  <= 16'h0000;
      seq_r     <= 16'h0000;
      loop_r    <= 1'b0;
      two_r     <= 1'b0;
      pfx_r     <= 1'b0;
      pc_r      <= 16'h0000;
      fl_r      <= 8'h00;
      cnt_r     <= 8'h00;
      cnt_we_r  <= 1'b0;
      done_r    <= 1'b0;
      handled_r <= 1'b0;
      taken_r   <= 1'b0;
      mc_r      <= 4'h0;
      ts_r      <= 5'h00;
    end else begin
      state_r   <= state_nxt;
      left_r    <= left_nxt;
      go_r      <= go_nxt;
      target_r  <= target_nxt;
      seq_r     <= seq_nxt;
      loop_r    <= loop_nxt;
      two_r     <= two_nxt;
      pfx_r     <= pfx_nxt;
      pc_r      <= pc_nxt;
      fl_r      <= fl_nxt;
      cnt_r     <= cnt_nxt;
      cnt_we_r  <= cnt_we_nxt;
      done_r    <= done_nxt;
      handled_r <= handled_nxt;
      taken_r   <= taken_nxt;
      mc_r      <= mc_nxt;
      ts_r      <= ts_nxt;
    end
  end

  // busy flag registered from the next state so it too is a flop
  logic busy_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != rib_pkg::RIB_IDLE);
    end
  end

  // outputs straight from flops
  assign busy_o            = busy_r;
  assign done_o            = done_r;
  assign handled_o         = handled_r;
  assign taken_o           = taken_r;
  assign program_counter_o = pc_r;
  assign flags_o           = fl_r;
  assign loop_count_o      = cnt_r;
  assign loop_count_we_o   = cnt_we_r;
  assign mcycles_o         = mc_r;
  assign tstates_o         = ts_r;

endmodule : rib_unit

/* hdl/rib_cfg.svh */
// rib_cfg.svh: opcode encodings and machine-cycle state counts for the branch unit
// assumes inclusion by bare name from the unit
`ifndef RIB_CFG_SVH
`define RIB_CFG_SVH

// opcode bytes
`define RIB_OP_JR_UNCOND   8'h18
`define RIB_OP_JR_CARRY_CLR 8'h30
`define RIB_OP_JR_ZERO_SET 8'h28
`define RIB_OP_JR_ZERO_CLR 8'h20
`define RIB_OP_JP_POINTER  8'hE9
`define RIB_OP_PFX_FIRST   8'hDD
`define RIB_OP_PFX_SECOND  8'hFD
`define RIB_OP_LOOP        8'h10

// flag register bit positions
`define RIB_FLAG_CARRY_BIT 0
`define RIB_FLAG_ZERO_BIT  6

// clock states per machine cycle
`define RIB_T_FETCH        4'h4
`define RIB_T_FETCH_LOOP   4'h5
`define RIB_T_DISP_READ    4'h3
`define RIB_T_ADD          4'h5
`define RIB_T_PFX_FETCH    4'h4

// one clock state is this many core clocks
`define RIB_STATE_CLOCKS   1

`endif

/* hdl/rib_pkg.sv */
// rib_pkg.sv: types shared by the branch unit
// assumes rib_cfg.svh is visible on the include path
package rib_pkg;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    RIB_IDLE  = 7'b000_0001, // waiting for an opcode
    RIB_FETCH = 7'b000_0010, // opcode fetch cycle
    RIB_PFX   = 7'b000_0100, // second fetch after an index prefix
    RIB_DISP  = 7'b000_1000, // displacement read cycle
    RIB_ADD   = 7'b001_0000, // target add cycle
    RIB_DONE  = 7'b010_0000, // one-cycle retire
    RIB_ERR   = 7'b100_0000  // unused code, not decoded here
  } rib_state_t;

  // instruction classes seen by the decoder
  typedef enum logic [2:0] {
    RIB_K_NONE = 3'h0,
    RIB_K_JR   = 3'h1,
    RIB_K_JP   = 3'h2,
    RIB_K_LOOP = 3'h3,
    RIB_K_PFX  = 3'h4
  } rib_kind_t;

endpackage : rib_pkg

/* bench/rib_unit_assertions.sv */
// rib_unit_assertions.sv: port-level timing and result checks of the branch unit
// assumes binding into rib_unit, one clock state per core clock
`timescale 1ns/1ns
module rib_unit_chk #(
  parameter int STATE_CLOCKS = 1 // delays below hold for 1 only
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        start_i,
  input wire logic [7:0]  opcode_i,
  input wire logic [7:0]  second_i,
  input wire logic [15:0] opcode_addr_i,
  input wire logic [7:0]  flags_i,
  input wire logic [7:0]  loop_count_i,
  input wire logic [15:0] pointer_pair_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        handled_o,
  input wire logic        taken_o,
  input wire logic [15:0] program_counter_o,
  input wire logic [7:0]  flags_o,
  input wire logic [7:0]  loop_count_o,
  input wire logic        loop_count_we_o,
  input wire logic [3:0]  mcycles_o,
  input wire logic [4:0]  tstates_o
);
  wire         acc = start_i && !busy_o; // request accepted
  logic [7:0]  flg_r, flg_nxt;           // flags at accept
  logic [7:0]  cnt_r, cnt_nxt;           // loop count at accept
  logic [15:0] adr_r, adr_nxt;           // opcode address at accept
  // inputs are only valid with start, so keep a copy for the retire check
  always_comb begin
    flg_nxt = acc ? flags_i : flg_r;
    cnt_nxt = acc ? loop_count_i : cnt_r;
    adr_nxt = acc ? opcode_addr_i : adr_r;
  end
  // capture registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flg_r <= 8'h00;
      cnt_r <= 8'h00;
      adr_r <= 16'h0000;
    end else begin
      flg_r <= flg_nxt;
      cnt_r <= cnt_nxt;
      adr_r <= adr_nxt;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // target and retire moment of the unconditional jump
  property p_always;
    logic [15:0] t;
    (acc && opcode_i == 8'h18, t = opcode_addr_i + 16'h0002 + {{8{second_i[7]}}, second_i})
      |-> ##14 done_o && taken_o && program_counter_o == t && tstates_o == 5'h0c;
  endproperty
  property p_pointer;
    logic [15:0] t;
    (acc && opcode_i == 8'he9, t = pointer_pair_i) |-> ##6 done_o && program_counter_o == t;
  endproperty
  a_jump_always: assert property (p_always)
    else $error("unconditional jump target or timing wrong");
  a_pointer_load: assert property (p_pointer)
    else $error("pointer jump target wrong");
  a_carry_set_skip: assert property (
    acc && opcode_i == 8'h30 && flags_i[0] |-> ##9 done_o && !taken_o)
    else $error("carry-clear jump taken with carry set");
  a_zero_set_go: assert property (
    acc && opcode_i == 8'h28 && flags_i[6] |-> ##14 done_o && taken_o)
    else $error("zero-set jump not taken");
  a_state_counts: assert property (
    done_o && handled_o |-> (mcycles_o == 4'h3 && tstates_o inside {5'h0c, 5'h0d}) ||
      (mcycles_o == 4'h2 && tstates_o inside {5'h07, 5'h08}) ||
      (mcycles_o == 4'h1 && tstates_o == 5'h04))
    else $error("cycle and state counts disagree");
  a_flags_kept: assert property (done_o && handled_o |-> flags_o == flg_r)
    else $error("flags changed");
  a_fall_through: assert property (
    done_o && handled_o && !taken_o |-> program_counter_o == adr_r + 16'h0002)
    else $error("untaken branch address wrong");
  a_loop_count: assert property (
    loop_count_we_o |-> done_o && loop_count_o == cnt_r - 8'h01 &&
      taken_o == (loop_count_o != 8'h00))
    else $error("loop count or decision wrong");
  a_loop_states: assert property (
    done_o && loop_count_we_o |-> tstates_o == (taken_o ? 5'h0d : 5'h08))
    else $error("loop state count wrong");
  // prefixed pointer jumps count the prefix fetch as their first cycle
  a_prefix_jump: assert property (
    acc && opcode_i inside {8'hdd, 8'hfd} && second_i == 8'he9 |->
      ##10 done_o && taken_o && mcycles_o == 4'h2 && tstates_o == 5'h08)
    else $error("prefixed pointer jump timing wrong");
  c_taken: cover property (done_o && taken_o);
  c_loop_out: cover property (loop_count_we_o && !taken_o);
  c_refused: cover property (done_o && !handled_o);
endmodule : rib_unit_chk

bind rib_unit rib_unit_chk #(.STATE_CLOCKS(STATE_CLOCKS)) chk_i (.clk_i, .reset_n_i, .start_i,
  .opcode_i, .second_i, .opcode_addr_i, .flags_i, .loop_count_i, .pointer_pair_i, .busy_o,
  .done_o, .handled_o, .taken_o, .program_counter_o, .flags_o, .loop_count_o,
  .loop_count_we_o, .mcycles_o, .tstates_o);

/* bench/rib_unit_tb.sv */
// rib_unit_tb.sv: self-checking bench of the branch unit
// assumes done arrives tstates+1 edges after the accepting edge
`timescale 1ns/1ns
module rib_unit_tb;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0; // clock, reset, strobe
  logic [7:0]  opcode_i = 8'h00, second_i = 8'h00;             // instruction bytes
  logic [7:0]  flags_i = 8'h00, loop_count_i = 8'h00;          // register inputs
  logic [15:0] opcode_addr_i = 16'h0000, pointer_pair_i = 16'h4800;
  logic [15:0] first_index_i = 16'h1234, second_index_i = 16'hbeef;
  logic        busy_o, done_o, handled_o, taken_o, loop_count_we_o; // status
  logic [15:0] program_counter_o;                             // next fetch address
  logic [7:0]  flags_o, loop_count_o;                          // register results
  logic [3:0]  mcycles_o;                                      // machine cycles
  logic [4:0]  tstates_o;                                      // clock states
  int          mismatches = 0, checks_done = 0, wait_n = 0;    // bookkeeping

  rib_unit #(.STATE_CLOCKS(1)) uut (.clk_i, .reset_n_i, .start_i, .opcode_i, .second_i,
    .opcode_addr_i, .flags_i, .loop_count_i, .pointer_pair_i, .first_index_i,
    .second_index_i, .busy_o, .done_o, .handled_o, .taken_o, .program_counter_o,
    .flags_o, .loop_count_o, .loop_count_we_o, .mcycles_o, .tstates_o);

  // 250 MHz core clock
  initial forever #2 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle request; inputs are only promised valid with start
  task automatic go(input logic [7:0] op, sec, fl, cnt, input logic [15:0] adr);
    @(posedge clk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    second_i <= sec;
    flags_i <= fl;
    loop_count_i <= cnt;
    opcode_addr_i <= adr;
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
  endtask : go

  // bounded wait for retire; wait_n counts edges after the accepting one
  task automatic wait_done;
    wait_n = 0;
    while (done_o !== 1'b1 && wait_n < 40) begin
      @(posedge clk_i);
      #1;
      wait_n++;
    end
  endtask : wait_done

  task automatic expect_res(input logic [15:0] pc, input logic tk, input logic [3:0] mc,
                            input logic [4:0] ts);
    chk(wait_n, ts + 1);
    chk(program_counter_o, pc);
    chk(taken_o, tk);
    chk(mcycles_o, mc);
    chk(tstates_o, ts);
    chk(handled_o, 1'b1);
    chk(flags_o, flags_i);
  endtask : expect_res

  task automatic t_uncond;
    go(8'h18, 8'h03, 8'h00, 8'h07, 16'h0480); wait_done; expect_res(16'h0485, 1, 3, 12);
    chk(loop_count_we_o, 1'b0);
    go(8'h18, 8'h80, 8'hff, 8'h07, 16'h0100); wait_done; expect_res(16'h0082, 1, 3, 12);
    go(8'h18, 8'h7f, 8'h00, 8'h07, 16'h0100); wait_done; expect_res(16'h0181, 1, 3, 12);
    go(8'h18, 8'h05, 8'h00, 8'h07, 16'hfffe); wait_done; expect_res(16'h0005, 1, 3, 12);
  endtask : t_uncond

  // each condition with its flag met and not met, other flag bits all set in one case and clear in the other
  task automatic t_cond;
    logic [7:0] ops [6] = '{8'h30, 8'h30, 8'h28, 8'h28, 8'h20, 8'h20};
    logic [7:0] fls [6] = '{8'hfe, 8'h01, 8'h40, 8'hbf, 8'hbf, 8'h40};
    logic       tks [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      go(ops[i], 8'hfa, fls[i], 8'h00, 16'h0480);
      wait_done;
      if (tks[i]) begin
        expect_res(16'h047c, 1, 3, 12);
      end else begin
        expect_res(16'h0482, 0, 2, 7);
      end
    end
  endtask : t_cond

  // prefixed jumps include the prefix fetch: two cycles, eight states
  task automatic t_pointer;
    go(8'he9, 8'h00, 8'h55, 8'h00, 16'h1000);
    wait_done;
    expect_res(16'h4800, 1, 1, 4);
    go(8'hdd, 8'he9, 8'h00, 8'h00, 16'h1000);
    wait_done;
    expect_res(16'h1234, 1, 2, 8);
    go(8'hfd, 8'he9, 8'h00, 8'h00, 16'h1000);
    wait_done;
    expect_res(16'hbeef, 1, 2, 8);
  endtask : t_pointer

  // count 2 loops, 1 falls out, 0 wraps round and loops
  task automatic t_loop;
    logic [7:0] cnts [3] = '{8'h02, 8'h01, 8'h00};
    for (int i = 0; i < 3; i++) begin
      go(8'h10, 8'hfe, 8'h00, cnts[i], 16'h0200);
      wait_done;
      chk(loop_count_we_o, 1'b1);
      chk(loop_count_o, 8'(cnts[i] - 8'h01));
      if (i == 1) begin
        expect_res(16'h0202, 0, 2, 8);
      end else begin
        expect_res(16'h0200, 1, 3, 13);
      end
    end
  endtask : t_loop

  // mid-run reset must clear every result register left by the loop test
  task automatic t_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({busy_o, done_o, handled_o, taken_o, loop_count_we_o, mcycles_o, tstates_o},
        32'h0000_0000);
    chk({program_counter_o, flags_o, loop_count_o}, 32'h0000_0000);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask : t_reset

  // prefix without the jump byte, then a start while busy
  task automatic t_refuse;
    go(8'hdd, 8'h00, 8'h00, 8'h00, 16'h0300); wait_done;
    chk(handled_o, 1'b0);
    chk(wait_n, 0);
    go(8'h18, 8'h03, 8'h00, 8'h00, 16'h0480);
    @(posedge clk_i);
    start_i <= 1'b1;
    opcode_i <= 8'he9;
    @(posedge clk_i);
    start_i <= 1'b0;
    wait_done;
    chk(program_counter_o, 16'h0485);
  endtask : t_refuse

  task automatic test_done;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_uncond();
    t_cond();
    t_pointer();
    t_loop();
    t_reset();
    t_refuse();
    test_done();
  end

  // watchdog, far beyond the few hundred cycles the scenarios need
  initial begin
    #40000;
    mismatches++;
    test_done();
  end
endmodule : rib_unit_tb
